// File: core/gpio_pkg.sv
// Operation
// - A port has up to eight pins, each input, interrupt input or output.
// - Bit N of direction, option and data controls pin N.
// - Direction clear makes the pin an input; data reads return pin level.
// - Data writes while input update the latch without touching the pin.
// - Interrupt inputs raise a request on the group's selected sensitivity.
// - Enabled pins of a group are NANDed before edge and level detection.
// - The request latch is hidden and clears on vector fetch; here it reads back through the status register.
// - Changing a group's sensitivity bits clears its pending request.
// - Direction set drives the latch; data reads return the latch.
// - Push-pull drives 0 low, 1 high; open-drain drives 0 low, 1 floats.
// - An active peripheral function overrides direction and data programming.
// - Peripheral output pins become outputs, push-pull or open-drain per peripheral.
// - Peripheral input pins are software inputs and stay readable through data.
// - Input pin with peripheral output enabled reads the peripheral output.
// - Output pin with peripheral input enabled feeds the latch to the peripheral.
// - Direction/option: 00 floating, 01 pull-up interrupt, 10 open-drain, 11 push-pull.
// - True open-drain pins: no pull-up, output always open-drain; here a peripheral output on them follows alt_out_od.
// - Sensitivity 00 falling and low, 01 rising, 10 falling, 11 both.
// - Sensitivity bits accept writes only while the CPU interrupt mask is set.
// - Data, direction and option registers reset to zero.
package gpio_pkg;
    localparam int          NPINS        = 8;
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFF_DATA     = 8'h00;
    localparam logic [7:0]  OFF_DIR      = 8'h04;
    localparam logic [7:0]  OFF_OPT      = 8'h08;
    localparam logic [7:0]  OFF_SENSE    = 8'h0c;
    localparam logic [7:0]  OFF_GROUP    = 8'h10;
    localparam logic [7:0]  OFF_STATUS   = 8'h14;
    localparam int          SENSE_A_LSB  = 0;
    localparam int          SENSE_B_LSB  = 2;
    localparam int          ST_PEND_A    = 0;
    localparam int          ST_PEND_B    = 1;
    localparam int          ST_MASK      = 2;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [7:0]  TRUE_OD_PINS = 8'h50;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        SENSE_FALL_LOW = 2'b00,
        SENSE_RISE     = 2'b01,
        SENSE_FALL     = 2'b10,
        SENSE_BOTH     = 2'b11
    } sense_t;

    typedef struct packed {
        logic [NPINS-1:0] out;
        logic [NPINS-1:0] oe_n;
        logic [NPINS-1:0] pull;
    } pad_t;
endpackage : gpio_pkg

// File: core/gpio_port.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gpio_port
    import gpio_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // External pins
    input  wire logic [NPINS-1:0]  pin_in,
    output logic [NPINS-1:0]       pin_out,
    output logic [NPINS-1:0]       pin_oe_n,
    output logic [NPINS-1:0]       pin_pull_up,
    // Peripheral alternate functions
    input  wire logic [NPINS-1:0]  alt_out_en,
    input  wire logic [NPINS-1:0]  alt_out_val,
    input  wire logic [NPINS-1:0]  alt_out_od,
    output logic [NPINS-1:0]       alt_in_val,
    // CPU interrupt interface
    input  wire logic              cpu_irq_mask,
    input  wire logic              vec_fetch_a,
    input  wire logic              vec_fetch_b,
    output logic                   ext_irq_group_a,
    output logic                   ext_irq_group_b
);
    logic [NPINS-1:0]  latch_r;
    logic [NPINS-1:0]  dir_r;
    logic [NPINS-1:0]  opt_r;
    logic [NPINS-1:0]  grp_r;
    sense_t            sense_r [2];
    logic [1:0]        pend_r;
    logic [1:0]        lvl_r;
    pad_t              pad_r;
    pad_t              pad_nxt;
    logic [NPINS-1:0]  alt_in_r;

    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [7:0]        wbyte_r;
    logic              wlane_r;

    logic              wr_fire;
    logic              wr_ok;
    logic              rd_fire;
    logic [NPINS-1:0]  rd_pins;
    logic [31:0]       rd_word;
    logic              rd_ok;
    logic [1:0]        evt;
    logic [1:0]        lvl;
    logic [1:0]        sense_chg;
    logic              sense_wr;
    sense_t            sense_new [2];

    assign awready         = awready_r;
    assign wready          = wready_r;
    assign bvalid          = bvalid_r;
    assign bresp           = bresp_r;
    assign arready         = arready_r;
    assign rvalid          = rvalid_r;
    assign rdata           = rdata_r;
    assign rresp           = rresp_r;
    assign pin_out         = pad_r.out;
    assign pin_oe_n        = pad_r.oe_n;
    assign pin_pull_up     = pad_r.pull;
    assign alt_in_val      = alt_in_r;
    assign ext_irq_group_a = pend_r[0];
    assign ext_irq_group_b = pend_r[1];

    // Write channel: address and data taken in either order
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;
    assign wr_ok   = (waddr_r == OFF_DATA) || (waddr_r == OFF_DIR) ||
                     (waddr_r == OFF_OPT) || (waddr_r == OFF_SENSE) ||
                     (waddr_r == OFF_GROUP) || (waddr_r == OFF_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            waddr_r   <= '0;
        end else if (awvalid && awready_r) begin
            awready_r <= 1'b0;
            waddr_r   <= awaddr;
        end else if (wr_fire) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            wbyte_r  <= BYTE_RESET;
            wlane_r  <= 1'b0;
        end else if (wvalid && wready_r) begin
            wready_r <= 1'b0;
            wbyte_r  <= wdata[7:0];
            wlane_r  <= wstrb[0];
        end else if (wr_fire) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Port registers, all cleared to floating inputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_r <= BYTE_RESET;
            dir_r   <= BYTE_RESET;
            opt_r   <= BYTE_RESET;
            grp_r   <= BYTE_RESET;
        end else if (wr_fire && wlane_r) begin
            // Latch always takes the write, whatever the direction
            if (waddr_r == OFF_DATA) latch_r <= wbyte_r;
            if (waddr_r == OFF_DIR)  dir_r   <= wbyte_r;
            if (waddr_r == OFF_OPT)  opt_r   <= wbyte_r;
            if (waddr_r == OFF_GROUP) grp_r  <= wbyte_r;
        end
    end

    // Sensitivity, writable only while interrupts are masked
    assign sense_wr     = wr_fire && wlane_r && (waddr_r == OFF_SENSE) && cpu_irq_mask;
    assign sense_new[0] = sense_t'(wbyte_r[SENSE_A_LSB +: 2]);
    assign sense_new[1] = sense_t'(wbyte_r[SENSE_B_LSB +: 2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_r[0] <= SENSE_FALL_LOW;
            sense_r[1] <= SENSE_FALL_LOW;
        end else if (sense_wr) begin
            sense_r[0] <= sense_new[0];
            sense_r[1] <= sense_new[1];
        end
    end

    // External interrupt groups
    for (genvar g = 0; g < 2; g++) begin : g_grp
        logic [NPINS-1:0] en;
        logic             evt_one;
        logic             lvl_one_r;
        logic             pend_one_r;
        assign en = ~dir_r & opt_r & (g == 0 ? ~grp_r : grp_r);
        // AND of enabled pins is the inverted NAND; one low pin masks the rest
        assign lvl[g] = &(pin_in | ~en);
        assign sense_chg[g] = sense_wr && (sense_new[g] != sense_r[g]);
        // One driver per group bit of the shared vectors
        assign evt[g]    = evt_one;
        assign lvl_r[g]  = lvl_one_r;
        assign pend_r[g] = pend_one_r;

        always_comb begin
            unique case (sense_r[g])
                SENSE_FALL_LOW: evt_one = (|en) && !lvl[g];
                SENSE_RISE:     evt_one = !lvl_one_r && lvl[g];
                SENSE_FALL:     evt_one = lvl_one_r && !lvl[g];
                SENSE_BOTH:     evt_one = lvl_one_r != lvl[g];
            endcase
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                lvl_one_r <= 1'b1;
            end else begin
                lvl_one_r <= lvl[g];
            end
        end

        // New event wins over vector fetch and sensitivity change
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pend_one_r <= 1'b0;
            end else if (evt_one) begin
                pend_one_r <= 1'b1;
            end else if ((g == 0 ? vec_fetch_a : vec_fetch_b) || sense_chg[g]) begin
                pend_one_r <= 1'b0;
            end
        end
    end

    // Pad drive: peripheral output overrides port programming
    always_comb begin
        logic [NPINS-1:0] drv;
        logic [NPINS-1:0] is_out;
        logic [NPINS-1:0] is_od;
        drv    = (alt_out_en & alt_out_val) | (~alt_out_en & latch_r);
        is_out = alt_out_en | dir_r;
        is_od  = (alt_out_en & alt_out_od) |
                 (~alt_out_en & (TRUE_OD_PINS | ~opt_r));
        pad_nxt.out  = drv & ~is_od;
        pad_nxt.oe_n = ~(is_out & ~(is_od & drv));
        pad_nxt.pull = ~is_out & opt_r & ~TRUE_OD_PINS;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_r.out  <= BYTE_RESET;
            pad_r.oe_n <= ~BYTE_RESET;
            pad_r.pull <= BYTE_RESET;
            alt_in_r   <= BYTE_RESET;
        end else begin
            pad_r    <= pad_nxt;
            alt_in_r <= (dir_r & latch_r) | (~dir_r & pin_in);
        end
    end

    // Read channel
    assign rd_fire = arvalid && arready_r;
    assign rd_pins = (dir_r & latch_r) |
                     (~dir_r & alt_out_en & alt_out_val) |
                     (~dir_r & ~alt_out_en & pin_in);

    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        unique case (araddr)
            OFF_DATA:   rd_word[NPINS-1:0] = rd_pins;
            OFF_DIR:    rd_word[NPINS-1:0] = dir_r;
            OFF_OPT:    rd_word[NPINS-1:0] = opt_r;
            OFF_GROUP:  rd_word[NPINS-1:0] = grp_r;
            OFF_SENSE: begin
                rd_word[SENSE_A_LSB +: 2] = sense_r[0];
                rd_word[SENSE_B_LSB +: 2] = sense_r[1];
            end
            // Pending latches visible for debug only, not clearable
            OFF_STATUS: begin
                rd_word[ST_PEND_A] = pend_r[0];
                rd_word[ST_PEND_B] = pend_r[1];
                rd_word[ST_MASK]   = cpu_irq_mask;
            end
            default:    rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= RESP_OKAY;
        end else if (rd_fire) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_word;
            rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    property p_reset_float;
        @(posedge aclk) !aresetn |=> (dir_r == BYTE_RESET) && (opt_r == BYTE_RESET)
            && (latch_r == BYTE_RESET);
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("port not cleared");

    property p_input_float;
        @(posedge aclk) disable iff (!aresetn)
            $past(aresetn) |-> ((~$past(dir_r) & ~$past(alt_out_en) & ~pin_oe_n) == '0);
    endproperty
    a_input_float: assert property (p_input_float) else $error("input pin driven");

    property p_push_pull;
        @(posedge aclk) disable iff (!aresetn)
            $past(aresetn) |-> (($past(dir_r & opt_r & ~alt_out_en) & ~TRUE_OD_PINS)
                & (pin_oe_n | (pin_out ^ $past(latch_r)))) == '0;
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull level wrong");

    property p_od_no_high;
        @(posedge aclk) disable iff (!aresetn)
            (pin_out & ~pin_oe_n & $past(~alt_out_en & dir_r & (TRUE_OD_PINS | ~opt_r))) == '0;
    endproperty
    a_od_no_high: assert property (p_od_no_high) else $error("open drain drove high");

    property p_sense_lock;
        @(posedge aclk) disable iff (!aresetn)
            (wr_fire && (waddr_r == OFF_SENSE) && !cpu_irq_mask) |=> $stable(sense_r[0])
                && $stable(sense_r[1]);
    endproperty
    a_sense_lock: assert property (p_sense_lock) else $error("sense written unmasked");

    property p_sense_clear;
        @(posedge aclk) disable iff (!aresetn)
            (sense_chg[0] && !evt[0]) |=> !pend_r[0];
    endproperty
    a_sense_clear: assert property (p_sense_clear) else $error("pending not discarded");

    property p_fetch_clear;
        @(posedge aclk) disable iff (!aresetn)
            (pend_r[1] && vec_fetch_b && !evt[1]) |=> !ext_irq_group_b;
    endproperty
    a_fetch_clear: assert property (p_fetch_clear) else $error("fetch kept request");

    property p_fall_sets;
        @(posedge aclk) disable iff (!aresetn)
            (sense_r[0] == SENSE_FALL && $past(lvl[0]) && !lvl[0]) |=> ext_irq_group_a;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

    property p_rise_ignored;
        @(posedge aclk) disable iff (!aresetn)
            (sense_r[0] == SENSE_RISE && !pend_r[0] && !lvl_r[0] && !lvl[0]) |=> !pend_r[0];
    endproperty
    a_rise_ignored: assert property (p_rise_ignored) else $error("masked group fired");

    property p_read_latch;
        @(posedge aclk) disable iff (!aresetn)
            (rd_fire && araddr == OFF_DATA) |=> rvalid
                && ((rdata[NPINS-1:0] ^ $past(latch_r)) & $past(dir_r)) == '0;
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("output read not latch");

    property p_write_resp;
        @(posedge aclk) disable iff (!aresetn)
            (awvalid && awready && wvalid && wready && !bvalid) |=> ##1 bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write answer late");
endmodule : gpio_port
`default_nettype wire

// File: dv/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pin_partner
    import gpio_pkg::*;
(
    // Clock
    input  wire logic             aclk,
    // Port pads
    input  wire logic [NPINS-1:0] pin_out,
    input  wire logic [NPINS-1:0] pin_oe_n,
    input  wire logic [NPINS-1:0] pin_pull_up,
    // Outside drivers
    input  wire logic [NPINS-1:0] ext_en,
    input  wire logic [NPINS-1:0] ext_val,
    output var  logic [NPINS-1:0] pin_lvl
);
    logic [NPINS-1:0] tgl_r = 8'h55;

    // Undriven pins wander every cycle
    always_ff @(posedge aclk) begin
        tgl_r <= ~tgl_r;
    end

    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (!pin_oe_n[i])
                pin_lvl[i] = pin_out[i];
            else if (ext_en[i])
                pin_lvl[i] = ext_val[i];
            else if (pin_pull_up[i])
                pin_lvl[i] = 1'b1;
            else
                pin_lvl[i] = tgl_r[i];
        end
    end
endmodule : pin_partner
`default_nettype wire

// File: dv/gpio_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_tb
    import gpio_pkg::*;
;
    logic              aclk = 0, aresetn = 0, cpu_irq_mask = 1;
    logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic              vec_fetch_a = 0, vec_fetch_b = 0;
    logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
    logic [31:0]       wdata = 0, rdata;
    logic [3:0]        wstrb = 0;
    logic [NPINS-1:0]  alt_out_en = 0, alt_out_val = 0, alt_out_od = 0;
    logic [NPINS-1:0]  ext_en = 8'hff, ext_val = 8'h3c;
    logic              awready, wready, bvalid, arready, rvalid, irq_a, irq_b;
    logic [1:0]        bresp, rresp;
    logic [NPINS-1:0]  pin_lvl, pin_out, pin_oe_n, pin_pull_up, alt_in_val;
    logic [7:0]        dir = 0, opt = 0, lat = 0, aen = 0;
    logic [33:0]       rq[$];
    logic [1:0]        bq[$];
    int                fail_count = 0, tests_run = 0, cyc = 0;
    integer            seed = 32'hc78e;

    gpio_port i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pin_in(pin_lvl), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .alt_out_en(alt_out_en),
        .alt_out_val(alt_out_val), .alt_out_od(alt_out_od), .alt_in_val(alt_in_val),
        .cpu_irq_mask(cpu_irq_mask), .vec_fetch_a(vec_fetch_a),
        .vec_fetch_b(vec_fetch_b), .ext_irq_group_a(irq_a), .ext_irq_group_b(irq_b));

    pin_partner i_pins (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_up(pin_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    function automatic logic [33:0] ok(input logic [7:0] v);
        return {RESP_OKAY, 24'h0, v};
    endfunction : ok

    // Result watcher: oldest note against each answer
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
        if (rvalid === 1'b1 && rready === 1'b1)
            check("read", {rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1 && bready === 1'b1)
            check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
        bit ta, tw;
        ta = 0;
        tw = 0;
        bq.push_back(resp);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!ta && awready === 1'b1) begin
                ta = 1;
                awvalid <= 1'b0;
            end
            if (!tw && wready === 1'b1) begin
                tw = 1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        bit ta;
        ta = 0;
        rq.push_back(exp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!ta && arready === 1'b1) begin
                ta = 1;
                arvalid <= 1'b0;
            end
        end while (!(ta && rvalid === 1'b1));
        rready <= 1'b0;
    endtask : rd

    task automatic pins();
        logic [7:0] oe, drv, pp;
        pp = dir & opt & ~TRUE_OD_PINS;
        oe = (aen & alt_out_od & alt_out_val) | (~aen & dir & ~pp & lat) | (~aen & ~dir);
        drv = ~oe & ((aen & alt_out_val) | (~aen & lat));
        repeat (2) @(posedge aclk);
        check("oe_n", pin_oe_n, oe);
        check("drive", pin_out & ~pin_oe_n, drv);
        check("pull", pin_pull_up, ~aen & ~dir & opt & ~TRUE_OD_PINS);
        check("alt_in", alt_in_val & (dir | ext_en), (dir & lat) | (ext_en & ext_val));
    endtask : pins

    task automatic cfg(input logic [7:0] d, o, l, ae);
        ext_en <= 8'h00;
        alt_out_en <= 8'h00;
        wr(OFF_DATA, l, RESP_OKAY);
        wr(OFF_OPT, o, RESP_OKAY);
        wr(OFF_DIR, d, RESP_OKAY);
        {dir, opt, lat, aen} = {d, o, l, ae};
        alt_out_en <= ae;
        ext_en <= ~d & ~ae;
        pins();
    endtask : cfg

    task automatic fetch();
        @(posedge aclk);
        vec_fetch_a <= 1'b1;
        vec_fetch_b <= 1'b1;
        @(posedge aclk);
        vec_fetch_a <= 1'b0;
        vec_fetch_b <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : fetch

    task automatic pin_set(input int i, input logic v);
        @(posedge aclk);
        ext_val[i] <= v;
        repeat (3) @(posedge aclk);
    endtask : pin_set

    initial begin
        logic [7:0] d, o, l, ae;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        pins();
        rd(OFF_DIR, ok(8'h00));
        rd(OFF_OPT, ok(8'h00));
        wr(OFF_DATA, 8'ha5, RESP_OKAY);
        lat = 8'ha5;
        pins();
        rd(OFF_DATA, ok(8'h3c));
        wr(8'h18, 8'h11, RESP_SLVERR);
        rd(8'h18, {RESP_SLVERR, 32'h0});
        for (int k = 0; k < 8; k++) begin
            d = 8'($random(seed));
            o = 8'($random(seed));
            l = 8'($random(seed));
            ae = 8'($random(seed)) & ~TRUE_OD_PINS & ~(~d & o);
            alt_out_val <= 8'($random(seed));
            alt_out_od <= 8'($random(seed));
            ext_val <= 8'($random(seed));
            cfg(d, o, l, ae);
            rd(OFF_DATA, ok((d & l) | (~d & ae & alt_out_val) | (~d & ~ae & ext_val)));
        end
        ext_val <= 8'hff;
        cfg(8'h00, 8'h03, 8'h00, 8'h00);
        wr(OFF_GROUP, 8'h00, RESP_OKAY);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_SENSE, 8'(c), RESP_OKAY);
            fetch();
            pin_set(0, 1'b0);
            check("fall", irq_a, c != 1);
            fetch();
            check("low", irq_a, c == 0);
            pin_set(0, 1'b1);
            check("rise", irq_a, c != 2);
            fetch();
        end
        wr(OFF_SENSE, 8'h01, RESP_OKAY);
        pin_set(1, 1'b0);
        pin_set(0, 1'b0);
        pin_set(0, 1'b1);
        check("masked", irq_a, 1'b0);
        pin_set(1, 1'b1);
        check("combined", irq_a, 1'b1);
        rd(OFF_STATUS, ok(8'h05));
        wr(OFF_SENSE, 8'h01, RESP_OKAY);
        check("same_sense", irq_a, 1'b1);
        wr(OFF_SENSE, 8'h02, RESP_OKAY);
        check("new_sense", irq_a, 1'b0);
        cpu_irq_mask <= 1'b0;
        wr(OFF_SENSE, 8'h0c, RESP_OKAY);
        rd(OFF_SENSE, ok(8'h02));
        cpu_irq_mask <= 1'b1;
        wr(OFF_GROUP, 8'h01, RESP_OKAY);
        wr(OFF_SENSE, 8'h04, RESP_OKAY);
        fetch();
        pin_set(0, 1'b0);
        pin_set(0, 1'b1);
        check("group_b", {irq_b, irq_a}, 2'b10);
        fetch();
        check("fetch_b", irq_b, 1'b0);
        // Mid-run reset must clear written configuration
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        {opt, lat} = '0;
        pins();
        rd(OFF_OPT, ok(8'h00));
        rd(OFF_GROUP, ok(8'h00));
        repeat (4) @(posedge aclk);
        check("drained", 34'(rq.size() + bq.size()), 34'h0);
        give_verdict();
    end
endmodule : gpio_port_tb
`default_nettype wire
